/* File: hw/dsam_mapper.sv */
// Status-to-assembly mapper with Avalon-MM register slave.
`timescale 1ns/10ps
`default_nettype none
`include "dsam_map.svh"

// Behaviour
// RULE1: Reverse flag = running and reverse bits.
// RULE2: Forward flag = running and forward bits.
// RULE3: Fault flag follows alarm bit 15.
// RULE4: Warning flag always reads zero.
// RULE5: Flags, state, speed low, speed high.
// RULE6: Ready in Ready, Enabled or Stopping.
// RULE7: Command-network flag when mode is network.
// RULE8: Speed-network flag when mode is network.
// RULE9: At-speed flag copies status bit 3.
// RULE10: State byte shows supervisor state.
// RULE11: Speed from frequency, converted if Hz.
// RULE12: Speed equals frequency times 120 over poles.
// RULE13: Conversion settings latched only at boot.
// RULE14: Input instance 150, 70 or 71 only.
// RULE15: Output instance 100, 20 or 21 only.
// RULE16: Vendor input words follow produced list.
// RULE17: Vendor output words go to listed registers.
// RULE18: Configuration assembly is ignored entirely.
// RULE19: Controller interval at least ten milliseconds; the mapper accepts a tick at any spacing and never uses DSAM_RPI_MIN_CYC.
// RULE20: Pole count zero means four poles.
// RULE21: Recompute everything before each exchange.
module dsam_mapper #(
    parameter int NWORDS = 4
) (
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // Avalon-MM slave.
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Produced exchange.
    input  wire logic        exch_tick,
    output logic [31:0]      ext_asm,
    output logic [31:0]      basic_asm,
    output logic [8*NWORDS-1:0] prod_regnums,
    output logic             asm_valid,
    // Consumed vendor words.
    input  wire logic        cons_valid,
    input  wire logic [16*NWORDS-1:0] cons_words,
    output logic [16*NWORDS-1:0] inv_wr_data,
    output logic [8*NWORDS-1:0]  inv_wr_regnum,
    output logic             inv_wr_valid
);

    if (NWORDS < 1 || NWORDS > 4) begin : g_bad_nwords
        $error("NWORDS must be 1 to 4");
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset release.
    logic rst_s1_q;
    logic rst_s2_q;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire logic rst_n = rst_s2_q;

    ////////////////////////////////////////////////////////////////////////
    // Registers.
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic asm_in_ok(input logic [7:0] n);
        return n == `DSAM_IN_VENDOR || n == `DSAM_IN_BASIC || n == `DSAM_IN_EXT;
    endfunction

    function automatic logic asm_out_ok(input logic [7:0] n);
        return n == `DSAM_OUT_VENDOR || n == `DSAM_OUT_BASIC || n == `DSAM_OUT_EXT;
    endfunction

    logic [31:0] ctrl_q, ctrl_d;
    logic [15:0] status_q, status_d;
    logic [15:0] opmode_q, opmode_d;
    logic [15:0] freq_q, freq_d;
    logic [15:0] p37_q, p37_d;
    logic [15:0] p144_q, p144_d;
    logic [31:0] inst_q, inst_d;
    logic [31:0] prod_list_q, prod_list_d;
    logic [31:0] cons_list_q, cons_list_d;
    logic [31:0] rdata_q, rdata_d;
    logic        ack_q, ack_d;
    logic        booted_q, booted_d;
    logic        conv_q, conv_d;
    logic [15:0] poles_q, poles_d;

    // A write lands at the edge where waitrequest is seen low, never earlier.
    wire logic wr_en = avs_write && ack_q;
    wire logic rd_en = avs_read && !ack_q;

    always_comb begin
        ctrl_d      = ctrl_q;
        status_d    = status_q;
        opmode_d    = opmode_q;
        freq_d      = freq_q;
        p37_d       = p37_q;
        p144_d      = p144_q;
        inst_d      = inst_q;
        prod_list_d = prod_list_q;
        cons_list_d = cons_list_q;
        ack_d       = (avs_read || avs_write) && !ack_q;
        rdata_d     = rdata_q;
        if (wr_en) begin
            unique case (avs_address)
                `DSAM_CTRL_OFS:      ctrl_d = be_merge(ctrl_q, avs_writedata, avs_byteenable);
                `DSAM_STATUS_OFS:    status_d = 16'(be_merge({16'h0, status_q}, avs_writedata,
                                                             avs_byteenable));
                `DSAM_OPMODE_OFS:    opmode_d = 16'(be_merge({16'h0, opmode_q}, avs_writedata,
                                                             avs_byteenable));
                `DSAM_FREQ_OFS:      freq_d = 16'(be_merge({16'h0, freq_q}, avs_writedata,
                                                           avs_byteenable));
                `DSAM_PARAM37_OFS:   p37_d = 16'(be_merge({16'h0, p37_q}, avs_writedata,
                                                          avs_byteenable));
                `DSAM_PARAM144_OFS:  p144_d = 16'(be_merge({16'h0, p144_q}, avs_writedata,
                                                           avs_byteenable));
                `DSAM_INST_OFS: begin
                    // RULE14 input instance check.
                    // RULE15 output instance check.
                    if (asm_in_ok(avs_writedata[7:0]) && asm_out_ok(avs_writedata[15:8])) begin
                        inst_d = be_merge(inst_q, avs_writedata, avs_byteenable);
                    end
                end
                `DSAM_PROD_LIST_OFS: prod_list_d = be_merge(prod_list_q, avs_writedata,
                                                            avs_byteenable);
                `DSAM_CONS_LIST_OFS: cons_list_d = be_merge(cons_list_q, avs_writedata,
                                                            avs_byteenable);
                // RULE18 configuration assembly ignored.
                `DSAM_CFG_OFS:       ctrl_d = ctrl_q;
                default:             ctrl_d = ctrl_q;
            endcase
        end
        if (rd_en) begin
            unique case (avs_address)
                `DSAM_CTRL_OFS:      rdata_d = ctrl_q;
                `DSAM_STATUS_OFS:    rdata_d = {16'h0, status_q};
                `DSAM_OPMODE_OFS:    rdata_d = {16'h0, opmode_q};
                `DSAM_FREQ_OFS:      rdata_d = {16'h0, freq_q};
                `DSAM_PARAM37_OFS:   rdata_d = {16'h0, p37_q};
                `DSAM_PARAM144_OFS:  rdata_d = {16'h0, p144_q};
                `DSAM_ASM_OFS:       rdata_d = ext_asm;
                `DSAM_SPEED_OFS:     rdata_d = {15'h0, conv_q, poles_q};
                `DSAM_INST_OFS:      rdata_d = inst_q;
                `DSAM_PROD_LIST_OFS: rdata_d = prod_list_q;
                `DSAM_CONS_LIST_OFS: rdata_d = cons_list_q;
                default:             rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q      <= 32'h0000_0000;
            status_q    <= 16'h0000;
            opmode_q    <= 16'h0000;
            freq_q      <= 16'h0000;
            p37_q       <= 16'h0000;
            p144_q      <= 16'h0000;
            inst_q      <= {16'h0, `DSAM_OUT_EXT, `DSAM_IN_EXT};
            prod_list_q <= 32'h0000_0000;
            cons_list_q <= 32'h0000_0000;
            rdata_q     <= 32'h0000_0000;
            ack_q       <= 1'b0;
        end else begin
            ctrl_q      <= ctrl_d;
            status_q    <= status_d;
            opmode_q    <= opmode_d;
            freq_q      <= freq_d;
            p37_q       <= p37_d;
            p144_q      <= p144_d;
            inst_q      <= inst_d;
            prod_list_q <= prod_list_d;
            cons_list_q <= cons_list_d;
            rdata_q     <= rdata_d;
            ack_q       <= ack_d;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign avs_readdata    = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Boot-time conversion choice.
    always_comb begin
        booted_d = 1'b1;
        conv_d   = conv_q;
        poles_d  = poles_q;
        // RULE13 sample once after reset.
        if (!booted_q) begin
            if (p144_q == 16'h0000) begin
                conv_d  = 1'b1;
                // RULE20 zero poles means four.
                poles_d = `DSAM_DEFAULT_POLES;
            end else if (p144_q <= `DSAM_P144_LOW_MAX) begin
                conv_d  = (p37_q != `DSAM_P37_RPM);
                poles_d = p144_q;
            end else begin
                conv_d  = (p37_q == `DSAM_P37_RPM);
                poles_d = p144_q - `DSAM_P144_HIGH;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            booted_q <= 1'b0;
            conv_q   <= 1'b1;
            poles_q  <= `DSAM_DEFAULT_POLES;
        end else begin
            booted_q <= booted_d;
            conv_q   <= conv_d;
            poles_q  <= poles_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Supervisor state and assembly build.
    dsam_pkg::dsam_sup_t sup_q, sup_d;
    dsam_pkg::dsam_flags_t flags_c;
    logic [31:0] prod32;
    logic [15:0] speed_c;
    logic [31:0] ext_q, ext_d;
    logic [31:0] basic_q, basic_d;
    logic        valid_q, valid_d;

    always_comb begin
        sup_d = sup_q;
        unique case (sup_q)
            dsam_pkg::DSAM_SUP_NONEXIST: sup_d = dsam_pkg::DSAM_SUP_STARTUP;
            dsam_pkg::DSAM_SUP_STARTUP:  sup_d = dsam_pkg::DSAM_SUP_NOTREADY;
            dsam_pkg::DSAM_SUP_NOTREADY: sup_d = booted_q ? dsam_pkg::DSAM_SUP_READY : sup_q;
            dsam_pkg::DSAM_SUP_READY:    sup_d = status_q[`DSAM_ST_RUN_BIT]
                                                 ? dsam_pkg::DSAM_SUP_ENABLED : sup_q;
            dsam_pkg::DSAM_SUP_ENABLED:  sup_d = status_q[`DSAM_ST_RUN_BIT]
                                                 ? sup_q : dsam_pkg::DSAM_SUP_STOPPING;
            dsam_pkg::DSAM_SUP_STOPPING: sup_d = dsam_pkg::DSAM_SUP_READY;
            dsam_pkg::DSAM_SUP_FAULTED:  sup_d = status_q[`DSAM_ST_ALARM_BIT]
                                                 ? sup_q : dsam_pkg::DSAM_SUP_NOTREADY;
            default:                     sup_d = dsam_pkg::DSAM_SUP_NONEXIST;
        endcase
        if (status_q[`DSAM_ST_ALARM_BIT] && sup_q != dsam_pkg::DSAM_SUP_NONEXIST) begin
            sup_d = dsam_pkg::DSAM_SUP_FAULTED;
        end
    end

    always_comb begin
        // RULE3 fault from alarm bit.
        flags_c.fault = status_q[`DSAM_ST_ALARM_BIT];
        // RULE4 warning never set.
        flags_c.warning = 1'b0;
        // RULE2 forward running.
        flags_c.forward_running_flag = status_q[`DSAM_ST_RUN_BIT] && status_q[`DSAM_ST_FWD_BIT];
        // RULE1 reverse running.
        flags_c.reverse_running_flag = status_q[`DSAM_ST_RUN_BIT] && status_q[`DSAM_ST_REV_BIT];
        // RULE6 ready states.
        flags_c.ready = sup_q inside {dsam_pkg::DSAM_SUP_READY, dsam_pkg::DSAM_SUP_ENABLED,
                                      dsam_pkg::DSAM_SUP_STOPPING};
        // RULE7 command from network.
        flags_c.command_source_network_flag = (opmode_q == `DSAM_NET_MODE);
        // RULE8 speed from network.
        flags_c.speed_source_network_flag = (opmode_q == `DSAM_NET_MODE);
        // RULE9 at speed.
        flags_c.at_speed_flag = status_q[`DSAM_ST_UPFREQ_BIT];
        // RULE12 frequency times 120 over poles.
        prod32 = {16'h0, freq_q} * `DSAM_HZ_TO_RPM;
        // RULE11 convert only when in Hz.
        speed_c = conv_q ? 16'((prod32 / {16'h0, poles_q})) : freq_q;
    end

    always_comb begin
        ext_d   = ext_q;
        basic_d = basic_q;
        valid_d = 1'b0;
        // RULE21 rebuild on each exchange.
        if (exch_tick) begin
            // RULE5 byte layout, speed low byte first.
            // RULE10 state byte.
            ext_d   = {speed_c, {1'b0, sup_q}, flags_c};
            basic_d = {speed_c, 8'h00, 5'h00, flags_c.forward_running_flag, 1'b0,
                       flags_c.fault};
            valid_d = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sup_q   <= dsam_pkg::DSAM_SUP_NONEXIST;
            ext_q   <= 32'h0000_0000;
            basic_q <= 32'h0000_0000;
            valid_q <= 1'b0;
        end else begin
            sup_q   <= sup_d;
            ext_q   <= ext_d;
            basic_q <= basic_d;
            valid_q <= valid_d;
        end
    end

    assign ext_asm   = ext_q;
    assign basic_asm = basic_q;
    assign asm_valid = valid_q;
    // RULE16 produced word order from list.
    assign prod_regnums = prod_list_q[8*NWORDS-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Consumed vendor words.
    logic [16*NWORDS-1:0] cw_q, cw_d;
    logic                 cv_q, cv_d;

    always_comb begin
        cw_d = cw_q;
        cv_d = cons_valid;
        if (cons_valid) begin
            cw_d = cons_words;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cw_q <= '0;
            cv_q <= 1'b0;
        end else begin
            cw_q <= cw_d;
            cv_q <= cv_d;
        end
    end

    // RULE17 word i goes to listed register i.
    assign inv_wr_data   = cw_q;
    assign inv_wr_regnum = cons_list_q[8*NWORDS-1:0];
    assign inv_wr_valid  = cv_q;

endmodule
`default_nettype wire

/* File: hw/dsam_map.svh */
// Offsets, field positions, reset values and timing counts of the status assembly mapper.
`ifndef DSAM_MAP_SVH
`define DSAM_MAP_SVH

`define DSAM_CTRL_OFS        4'h0
`define DSAM_STATUS_OFS      4'h1
`define DSAM_OPMODE_OFS      4'h2
`define DSAM_FREQ_OFS        4'h3
`define DSAM_PARAM37_OFS     4'h4
`define DSAM_PARAM144_OFS    4'h5
`define DSAM_ASM_OFS         4'h6
`define DSAM_SPEED_OFS       4'h7
`define DSAM_CFG_OFS         4'h8
`define DSAM_PROD_LIST_OFS   4'h9
`define DSAM_CONS_LIST_OFS   4'hA
`define DSAM_INST_OFS        4'hB

`define DSAM_ST_RUN_BIT      0
`define DSAM_ST_FWD_BIT      1
`define DSAM_ST_REV_BIT      2
`define DSAM_ST_UPFREQ_BIT   3
`define DSAM_ST_ALARM_BIT    15
`define DSAM_NET_MODE        16'h0004
`define DSAM_HZ_TO_RPM       32'h0000_0078
`define DSAM_DEFAULT_POLES   16'h0004
`define DSAM_P37_RPM         16'h4E1E
`define DSAM_P144_HIGH       16'h0064
`define DSAM_P144_LOW_MAX    16'h000A

`define DSAM_IN_VENDOR       8'h96
`define DSAM_IN_BASIC        8'h46
`define DSAM_IN_EXT          8'h47
`define DSAM_OUT_VENDOR      8'h64
`define DSAM_OUT_BASIC       8'h14
`define DSAM_OUT_EXT         8'h15

`define DSAM_RPI_MIN_MS      10
`define DSAM_CLK_MHZ         125
`define DSAM_RPI_MIN_CYC     (`DSAM_RPI_MIN_MS * 1000 * `DSAM_CLK_MHZ)

`endif

/* File: hw/dsam_pkg.sv */
// Types of the status assembly mapper.
package dsam_pkg;

    typedef enum logic [6:0] {
        DSAM_SUP_NONEXIST = 7'h01,
        DSAM_SUP_STARTUP  = 7'h02,
        DSAM_SUP_NOTREADY = 7'h04,
        DSAM_SUP_READY    = 7'h08,
        DSAM_SUP_ENABLED  = 7'h10,
        DSAM_SUP_STOPPING = 7'h20,
        DSAM_SUP_FAULTED  = 7'h40
    } dsam_sup_t;

    typedef struct packed {
        logic at_speed_flag;
        logic speed_source_network_flag;
        logic command_source_network_flag;
        logic ready;
        logic reverse_running_flag;
        logic forward_running_flag;
        logic warning;
        logic fault;
    } dsam_flags_t;

    typedef struct packed {
        logic [15:0] speed;
        logic [7:0]  state;
        dsam_flags_t flags;
    } dsam_ext_asm_t;

endpackage

/* File: bench/dsam_mapper_monitor.sv */
// Concurrent checks on the ports of the status assembly mapper.
`timescale 1ns/10ps
`default_nettype none
module dsam_mapper_monitor #(
    parameter int NWORDS = 4
) (
    // Clock and reset.
    input wire logic                  mclk,
    input wire logic                  rst_b,
    // Produced and consumed sides.
    input wire logic                  exch_tick,
    input wire logic                  asm_valid,
    input wire logic [31:0]           ext_asm,
    input wire logic [31:0]           basic_asm,
    input wire logic                  cons_valid,
    input wire logic [16*NWORDS-1:0]  cons_words,
    input wire logic                  inv_wr_valid,
    input wire logic [16*NWORDS-1:0]  inv_wr_data
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////////////
    tick_to_valid_a: assert property (exch_tick |=> asm_valid)
        else $error("assembly not rebuilt one cycle after tick");
    valid_has_cause_a: assert property (asm_valid |-> $past(exch_tick))
        else $error("assembly valid without a tick");
    warning_zero_a: assert property (ext_asm[1] == 1'b0)
        else $error("warning flag set");
    ready_by_state_a: assert property (ext_asm[4] == ((ext_asm[15:8] & 8'h38) != 8'h00))
        else $error("ready flag disagrees with state byte");
    net_flags_agree_a: assert property (ext_asm[5] == ext_asm[6])
        else $error("network source flags differ");
    state_one_hot_a: assert property ($onehot0(ext_asm[15:8]))
        else $error("state byte not a single state");
    cons_write_a: assert property (cons_valid |=> inv_wr_valid
        && inv_wr_data == $past(cons_words))
        else $error("consumed words not passed to register writes");
    basic_matches_a: assert property (basic_asm[31:16] == ext_asm[31:16]
        && basic_asm[2] == ext_asm[2] && basic_asm[0] == ext_asm[0])
        else $error("basic assembly disagrees with extended");
    cover property (exch_tick ##1 asm_valid);
    cover property (cons_valid ##1 inv_wr_valid);
    cover property (ext_asm[3] && ext_asm[0]);
    cover property (ext_asm[5] && ext_asm[7]);
endmodule
bind dsam_mapper dsam_mapper_monitor #(.NWORDS(NWORDS)) u_mon (.mclk(mclk), .rst_b(rst_b),
    .exch_tick(exch_tick), .asm_valid(asm_valid), .ext_asm(ext_asm), .basic_asm(basic_asm),
    .cons_valid(cons_valid), .cons_words(cons_words), .inv_wr_valid(inv_wr_valid),
    .inv_wr_data(inv_wr_data));
`default_nettype wire

/* File: bench/dsam_scanner.sv */
// Model of the network scanner that paces exchanges and sends consumed words.
`timescale 1ns/10ps
`default_nettype none
module dsam_scanner #(
    parameter int NWORDS = 4,
    parameter int GAP    = 6
) (
    // Clock and reset.
    input wire logic                  mclk,
    input wire logic                  rst_b,
    // Bench requests.
    input wire logic                  exch_req,
    input wire logic                  cons_req,
    input wire logic [16*NWORDS-1:0]  cons_data,
    // Toward the mapper.
    output logic                      exch_tick,
    output logic                      cons_valid,
    output logic [16*NWORDS-1:0]      cons_words
);
    logic     done_q;
    logic     cdone_q;
    int       gap_q;
    logic     fire;
    logic     cfire;
    // interval kept: a tick waits until the gap since the last one ran out.
    assign fire  = exch_req && !done_q && gap_q == 0;
    // whole consumed block: all words travel in one valid cycle.
    assign cfire = cons_req && !cdone_q;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            exch_tick  <= 1'b0;
            cons_valid <= 1'b0;
            cons_words <= '0;
            done_q     <= 1'b0;
            cdone_q    <= 1'b0;
            gap_q      <= 0;
        end else begin
            exch_tick  <= fire;
            cons_valid <= cfire;
            // Idle words toggle so stale data is never mistaken for fresh.
            cons_words <= cfire ? cons_data : ~cons_words;
            done_q     <= exch_req && (done_q || fire);
            cdone_q    <= cons_req;
            gap_q      <= fire ? GAP : (gap_q != 0 ? gap_q - 1 : 0);
        end
    end
endmodule
`default_nettype wire

/* File: bench/tb_drive_status_assembly_mapper.sv */
// Self-checking bench of the status assembly mapper.
`timescale 1ns/10ps
`default_nettype none
`include "dsam_map.svh"
module tb_drive_status_assembly_mapper;
    localparam int NW = 4;
    logic            mclk = 1'b0;
    logic            rst_b = 1'b0;
    logic [3:0]      avs_address = 4'h0;
    logic            avs_read = 1'b0;
    logic            avs_write = 1'b0;
    logic [31:0]     avs_writedata = 32'h0000_0000;
    logic [3:0]      avs_byteenable = 4'hF;
    logic [31:0]     avs_readdata;
    logic            avs_waitrequest;
    logic            exch_req = 1'b0;
    logic            cons_req = 1'b0;
    logic [16*NW-1:0] cons_data = '0;
    logic            exch_tick;
    logic            cons_valid;
    logic [16*NW-1:0] cons_words;
    logic [31:0]     ext_asm;
    logic [31:0]     basic_asm;
    logic [8*NW-1:0] prod_regnums;
    logic            asm_valid;
    logic [16*NW-1:0] inv_wr_data;
    logic [8*NW-1:0] inv_wr_regnum;
    logic            inv_wr_valid;
    logic [31:0]     rd;
    int              miscompares = 0;
    int              num_checks = 0;
    int              cyc = 0;

    always #4 mclk = ~mclk;

    dsam_mapper #(.NWORDS(NW)) DUT (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .exch_tick(exch_tick), .ext_asm(ext_asm),
        .basic_asm(basic_asm), .prod_regnums(prod_regnums), .asm_valid(asm_valid),
        .cons_valid(cons_valid), .cons_words(cons_words), .inv_wr_data(inv_wr_data),
        .inv_wr_regnum(inv_wr_regnum), .inv_wr_valid(inv_wr_valid));
    dsam_scanner #(.NWORDS(NW), .GAP(6)) u_scan (.mclk(mclk), .rst_b(rst_b),
        .exch_req(exch_req), .cons_req(cons_req), .cons_data(cons_data),
        .exch_tick(exch_tick), .cons_valid(cons_valid), .cons_words(cons_words));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch t=%0t %s seen=%h exp=%h", $time, what, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    // One bus cycle; the request stands until waitrequest is seen low at a rising edge.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(negedge mclk);
    endtask

    task automatic exch();
        @(posedge mclk);
        exch_req <= 1'b1;
        do @(negedge mclk); while (asm_valid !== 1'b1);
        @(posedge mclk);
        exch_req <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_flags();
        logic [15:0] st [6] = '{16'h0003, 16'h0005, 16'h0006, 16'h8008, 16'h0001, 16'h800F};
        logic [15:0] om [6] = '{16'h0004, 16'h0010, 16'h0004, 16'h0014, 16'h0000, 16'h0004};
        logic [15:0] fr [6] = '{16'h04D2, 16'h0000, 16'h07D0, 16'h0001, 16'h0888, 16'h0100};
        logic [7:0] fl;
        logic [15:0] sp;
        logic n;
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, `DSAM_STATUS_OFS, {16'h0000, st[i]});
            bus(1'b1, `DSAM_OPMODE_OFS, {16'h0000, om[i]});
            bus(1'b1, `DSAM_FREQ_OFS, {16'h0000, fr[i]});
            exch();
            n  = om[i] == `DSAM_NET_MODE;
            fl = {st[i][3], n, n, 1'b0, st[i][0] & st[i][2], st[i][0] & st[i][1], 1'b0, st[i][15]};
            sp = 16'((32'(fr[i]) * `DSAM_HZ_TO_RPM) / 32'(`DSAM_DEFAULT_POLES));
            // flags from status and mode, ready masked out.
            chk(ext_asm[7:0] & 8'hEF, fl, "flags");
            chk(ext_asm[31:16], sp, "speed");
            chk(basic_asm, {sp, 8'h00, 5'h00, fl[2], 1'b0, fl[0]}, "basic");
        end
    endtask

    task automatic t_boot();
        bus(1'b1, `DSAM_PARAM144_OFS, 32'h0000_0006);
        bus(1'b1, `DSAM_PARAM37_OFS, {16'h0000, `DSAM_P37_RPM});
        bus(1'b1, `DSAM_FREQ_OFS, 32'h0000_0064);
        exch();
        // boot choice of four poles stays in force.
        chk(ext_asm[31:16], 16'h0BB8, "boot latch");
    endtask

    task automatic t_regs();
        bus(1'b0, `DSAM_INST_OFS, 32'h0000_0000);
        chk(rd, 32'h0000_1547, "instance after reset");
        bus(1'b1, `DSAM_INST_OFS, 32'h0000_6496);
        bus(1'b0, `DSAM_INST_OFS, 32'h0000_0000);
        chk(rd, 32'h0000_6496, "instance 150");
        bus(1'b1, `DSAM_INST_OFS, 32'h0000_6433);
        bus(1'b0, `DSAM_INST_OFS, 32'h0000_0000);
        chk(rd, 32'h0000_6496, "bad instance");
        bus(1'b1, `DSAM_INST_OFS, 32'h0000_1547);
        bus(1'b0, `DSAM_INST_OFS, 32'h0000_0000);
        chk(rd, 32'h0000_1547, "instance 71");
        bus(1'b1, `DSAM_INST_OFS, 32'h0000_3347);
        bus(1'b0, `DSAM_INST_OFS, 32'h0000_0000);
        chk(rd, 32'h0000_1547, "bad output instance");
        bus(1'b1, `DSAM_CFG_OFS, 32'h0000_0001);
        bus(1'b0, `DSAM_CFG_OFS, 32'h0000_0000);
        chk(rd, 32'h0000_0000, "config");
        bus(1'b0, 4'hC, 32'h0000_0000);
        chk(rd, 32'h0000_0000, "unmapped");
    endtask

    task automatic t_lists();
        bus(1'b1, `DSAM_PROD_LIST_OFS, 32'hC9C8_0D05);
        chk(prod_regnums, 32'hC9C8_0D05, "produced list");
        bus(1'b1, `DSAM_CONS_LIST_OFS, 32'h0E09_0A02);
        @(posedge mclk);
        cons_req  <= 1'b1;
        cons_data <= 64'h1234_0002_ABCD_4321;
        do @(negedge mclk); while (inv_wr_valid !== 1'b1);
        chk(inv_wr_data, 64'h1234_0002_ABCD_4321, "consumed data");
        chk(inv_wr_regnum, 32'h0E09_0A02, "consumed regs");
        @(posedge mclk);
        cons_req <= 1'b0;
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
        t_flags();
        t_boot();
        t_regs();
        t_lists();
        tally_and_finish();
    end
endmodule
`default_nettype wire
